// ### pkg/fhc_pkg.sv
// Constants and types for the parallel NOR flash host controller.
package fhc_pkg;
  // Bus widths of the flash, internal counter widths and read sync depth.
  localparam int ADDR_W     = 21;
  localparam int DATA_W     = 16;
  localparam int CMD_ADDR_W = 12;
  localparam int CNT_W      = 4;
  localparam int STEP_W     = 3;
  localparam int TMO_W      = 32;
  localparam int SYNC_STAGES = 2;

  // Clock rate in MHz.
  localparam int CLK_MHZ = 20;

  // Pin timing in ns; minima round up to whole cycles.
  localparam int T_WP_NS   = 25;
  localparam int T_WPH_NS  = 15;
  localparam int T_ACC_NS  = 80;
  localparam int T_OEHP_NS = 50;
  localparam int T_RP_NS   = 500;
  localparam int WP_CYC   = ((T_WP_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 : (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int WPH_CYC  = ((T_WPH_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 : (T_WPH_NS * CLK_MHZ + 999) / 1000;
  localparam int ACC_CYC  = ((T_ACC_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 : (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int OEHP_CYC = ((T_OEHP_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 : (T_OEHP_NS * CLK_MHZ + 999) / 1000;
  localparam int RP_CYC   = (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam int RD_CYC   = ACC_CYC + SYNC_STAGES;

  // Completion limits: program and suspend in us, erases in ms.
  localparam int WORD_PROGRAM_MAX_US        = 120;
  localparam int SMALL_SECTOR_ERASE_MAX_MS  = 2000;
  localparam int LARGE_SECTOR_ERASE_MAX_MS  = 6000;
  localparam int WHOLE_ARRAY_ERASE_TYP_MS   = 33000;
  localparam int SUSPEND_MAX_US             = 15;
  localparam int PROG_CYC  = WORD_PROGRAM_MAX_US * CLK_MHZ;
  localparam int SUSP_CYC  = SUSPEND_MAX_US * CLK_MHZ;
  localparam int SMALL_CYC = SMALL_SECTOR_ERASE_MAX_MS * CLK_MHZ * 1000;
  localparam int LARGE_CYC = LARGE_SECTOR_ERASE_MAX_MS * CLK_MHZ * 1000;
  localparam int CHIP_CYC  = WHOLE_ARRAY_ERASE_TYP_MS * CLK_MHZ * 1000;

  // Command cycle addresses and data codes.
  localparam logic [CMD_ADDR_W-1:0] UNLOCK_ADDR1 = 12'h555;
  localparam logic [CMD_ADDR_W-1:0] UNLOCK_ADDR2 = 12'h2AA;
  localparam logic [7:0] CMD_UNLOCK1  = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2  = 8'h55;
  localparam logic [7:0] CMD_PROGRAM  = 8'hA0;
  localparam logic [7:0] CMD_ERASE    = 8'h80;
  localparam logic [7:0] CMD_SECTOR   = 8'h30;
  localparam logic [7:0] CMD_CHIP     = 8'h10;
  localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
  localparam logic [7:0] CMD_ID_EXIT  = 8'hF0;
  localparam logic [7:0] CMD_SUSPEND  = 8'hB0;
  localparam logic [7:0] CMD_RESUME   = 8'hD0;

  // Status bit and small sector decode.
  localparam int TOGGLE_BIT = 6;
  localparam int SECTOR_LSB = 15;
  localparam logic [ADDR_W-SECTOR_LSB-1:0] SMALL_SECTOR_TAG = 6'h3F;

  // Operations that the user port can request.
  typedef enum logic [3:0] {
    FHC_OP_READ, FHC_OP_PROGRAM, FHC_OP_SECTOR_ERASE, FHC_OP_CHIP_ERASE,
    FHC_OP_ID_ENTRY, FHC_OP_ID_EXIT, FHC_OP_ID_EXIT_SHORT, FHC_OP_SUSPEND,
    FHC_OP_RESUME
  } fhc_op_type;
endpackage

// ### pkg/fhc_cyc_if.sv
// Bus cycle request and answer between sequencer and pin engine.
`timescale 1ns/1ps
interface fhc_cyc_if;
  logic                        req;
  logic                        wr;
  logic [fhc_pkg::ADDR_W-1:0]  addr;
  logic [fhc_pkg::DATA_W-1:0]  wdata;
  logic                        ack;
  logic [fhc_pkg::DATA_W-1:0]  rdata;
  modport master (output req, wr, addr, wdata, input ack, rdata);
  modport slave  (input req, wr, addr, wdata, output ack, rdata);
endinterface

// ### rtl/fhc_cycle.sv
// Pin engine: one flash read or write cycle per request.
`timescale 1ns/1ps
module fhc_cycle (
  input  wire logic                        clk_sys_i,
  input  wire logic                        rst_i,
  fhc_cyc_if.slave                         cyc,
  output logic                             ce_n_o,
  output logic                             oe_n_o,
  output logic                             we_n_o,
  output logic [fhc_pkg::ADDR_W-1:0]       addr_o,
  output logic [fhc_pkg::DATA_W-1:0]       dq_o,
  output logic                             dq_oe_o,
  input  wire logic [fhc_pkg::DATA_W-1:0]  dq_i
);
  import fhc_pkg::*;

  typedef enum logic [2:0] {C_IDLE, C_WSETUP, C_WPULSE, C_WHIGH, C_RACC, C_RREC, C_DONE} fhc_cstate_type;

  fhc_cstate_type     cst;
  logic [CNT_W-1:0]   cnt;
  logic [DATA_W-1:0]  dq_s1;
  logic [DATA_W-1:0]  dq_s2;
  logic [DATA_W-1:0]  rdata;

  wire cnt_zero = (cnt == '0);
  assign cyc.ack   = (cst == C_DONE);
  assign cyc.rdata = rdata;

  // Read data crosses from the pins through two flops.
  always_ff @(posedge clk_sys_i) begin
    dq_s1 <= dq_i;
    dq_s2 <= dq_s1;
  end

  // Output enable stays high for a whole write, so the bus never fights.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cst <= C_IDLE;
      cnt <= '0;
      ce_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      we_n_o <= 1'b1;
      dq_oe_o <= 1'b0;
      addr_o <= '0;
      dq_o <= '0;
      rdata <= '0;
    end else begin
      cnt <= cnt_zero ? cnt : cnt - 1'b1;
      case (cst)
        C_IDLE: if (cyc.req) begin
          addr_o <= cyc.addr;
          dq_o <= cyc.wdata;
          ce_n_o <= 1'b0;
          dq_oe_o <= cyc.wr;
          oe_n_o <= cyc.wr;
          cnt <= CNT_W'(RD_CYC - 1);
          cst <= cyc.wr ? C_WSETUP : C_RACC;
        end
        C_WSETUP: begin
          we_n_o <= 1'b0;
          cnt <= CNT_W'(WP_CYC - 1);
          cst <= C_WPULSE;
        end
        C_WPULSE: if (cnt_zero) begin
          we_n_o <= 1'b1;
          cnt <= CNT_W'(WPH_CYC - 1);
          cst <= C_WHIGH;
        end
        C_WHIGH: if (cnt_zero) begin
          ce_n_o <= 1'b1;
          dq_oe_o <= 1'b0;
          cst <= C_DONE;
        end
        C_RACC: if (cnt_zero) begin
          rdata <= dq_s2;
          oe_n_o <= 1'b1;
          ce_n_o <= 1'b1;
          cnt <= CNT_W'(OEHP_CYC - 1);
          cst <= C_RREC;
        end
        C_RREC: if (cnt_zero) begin
          cst <= C_DONE;
        end
        default: cst <= C_IDLE;
      endcase
    end
  end

  localparam int WP_DLY = WP_CYC;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_oe_high_write: assert property ((!we_n_o && !ce_n_o) |-> oe_n_o)
    else $error("Output enable low during a write strobe.");
  a_we_pulse_width: assert property ($fell(we_n_o) |-> !we_n_o ##WP_DLY we_n_o)
    else $error("Write strobe width is wrong.");
  a_cycle_ack_bound: assert property ((cst == C_IDLE && cyc.req) |-> ##[3:8] cyc.ack)
    else $error("Bus cycle did not finish in time.");
endmodule

// ### rtl/fhc_ctrl.sv
// Host controller that sequences commands to a parallel NOR flash.
//
// Summary of operation
// - Chip erase last write at 555; sector inside.
// - Last erase write data 10 chip, 30 sector.
// - Output enable high while write strobe active.
// - Status polling keeps one fixed address.
// - Only status change between reads matters.
`timescale 1ns/1ps
module fhc_ctrl #(
  parameter int unsigned SMALL_ERASE_TMO = fhc_pkg::SMALL_CYC,
  parameter int unsigned LARGE_ERASE_TMO = fhc_pkg::LARGE_CYC,
  parameter int unsigned CHIP_ERASE_TMO  = fhc_pkg::CHIP_CYC
) (
  input  wire logic                        clk_sys_i,
  input  wire logic                        rst_i,
  input  wire logic                        cmd_valid_i,
  input  wire fhc_pkg::fhc_op_type         cmd_op_i,
  input  wire logic [fhc_pkg::ADDR_W-1:0]  cmd_addr_i,
  input  wire logic [fhc_pkg::DATA_W-1:0]  cmd_data_i,
  output logic                             cmd_ready_o,
  output logic                             done_o,
  output logic                             error_o,
  output logic [fhc_pkg::DATA_W-1:0]       rdata_o,
  output logic                             flash_rst_n_o,
  output logic                             flash_ce_n_o,
  output logic                             flash_oe_n_o,
  output logic                             flash_we_n_o,
  output logic [fhc_pkg::ADDR_W-1:0]       flash_addr_o,
  output logic [fhc_pkg::DATA_W-1:0]       flash_dq_o,
  output logic                             flash_dq_oe_o,
  input  wire logic [fhc_pkg::DATA_W-1:0]  flash_dq_i
);
  import fhc_pkg::*;

  typedef enum logic [2:0] {S_RESET, S_IDLE, S_WRITE, S_READ, S_POLL, S_SUSP_WAIT} fhc_state_type;

  // Number of the last write step of each command.
  function automatic logic [STEP_W-1:0] fhc_last_step(input fhc_op_type op);
    case (op)
      FHC_OP_PROGRAM:      fhc_last_step = 3'h3;
      FHC_OP_SECTOR_ERASE: fhc_last_step = 3'h5;
      FHC_OP_CHIP_ERASE:   fhc_last_step = 3'h5;
      FHC_OP_ID_ENTRY:     fhc_last_step = 3'h2;
      FHC_OP_ID_EXIT:      fhc_last_step = 3'h2;
      default:             fhc_last_step = 3'h0;
    endcase
  endfunction

  // Address and data byte of one command write; upper bits stay zero.
  function automatic logic [CMD_ADDR_W+7:0] fhc_seq(input fhc_op_type op, input logic [STEP_W-1:0] step);
    logic [7:0] d;
    logic       second;
    second = (step == 3'h1) || (step == 3'h4);
    case (op)
      FHC_OP_PROGRAM:       d = CMD_PROGRAM;
      FHC_OP_SECTOR_ERASE:  d = (step == 3'h5) ? CMD_SECTOR : CMD_ERASE;
      FHC_OP_CHIP_ERASE:    d = (step == 3'h5) ? CMD_CHIP : CMD_ERASE;
      FHC_OP_ID_ENTRY:      d = CMD_ID_ENTRY;
      FHC_OP_ID_EXIT:       d = CMD_ID_EXIT;
      FHC_OP_ID_EXIT_SHORT: d = CMD_ID_EXIT;
      FHC_OP_SUSPEND:       d = CMD_SUSPEND;
      default:              d = CMD_RESUME;
    endcase
    if (fhc_last_step(op) != 3'h0 && (step == 3'h0 || step == 3'h3)) begin
      d = CMD_UNLOCK1;
    end
    if (second) begin
      d = CMD_UNLOCK2;
    end
    fhc_seq = {second ? UNLOCK_ADDR2 : UNLOCK_ADDR1, d};
  endfunction

  fhc_state_type      state;
  fhc_state_type      next_state;
  fhc_op_type         op;
  logic [ADDR_W-1:0]  uaddr;
  logic [DATA_W-1:0]  udata;
  logic [STEP_W-1:0]  step;
  logic [TMO_W-1:0]   timer;
  logic [CNT_W-1:0]   rst_cnt;
  logic               first;
  logic               prev_tog;
  logic [TMO_W-1:0]   tmo_val;

  fhc_cyc_if cyc ();

  fhc_cycle u_cycle (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .cyc       (cyc.slave),
    .ce_n_o    (flash_ce_n_o),
    .oe_n_o    (flash_oe_n_o),
    .we_n_o    (flash_we_n_o),
    .addr_o    (flash_addr_o),
    .dq_o      (flash_dq_o),
    .dq_oe_o   (flash_dq_oe_o),
    .dq_i      (flash_dq_i)
  );

  // Command decode for the current step.
  wire [CMD_ADDR_W+7:0] seq_word = fhc_seq(op, step);
  wire last_step = (step == fhc_last_step(op));
  wire user_last = (op != FHC_OP_CHIP_ERASE) && (op != FHC_OP_ID_ENTRY) && (op != FHC_OP_ID_EXIT);
  wire use_user  = last_step && user_last;
  wire poll_op   = (op == FHC_OP_PROGRAM) || (op == FHC_OP_SECTOR_ERASE) || (op == FHC_OP_CHIP_ERASE);
  wire small_sec = (uaddr[ADDR_W-1:SECTOR_LSB] == SMALL_SECTOR_TAG);
  wire [ADDR_W-1:0] seq_addr = use_user ? uaddr : {{(ADDR_W-CMD_ADDR_W){1'b0}}, seq_word[CMD_ADDR_W+7:8]};
  // Only the program data word uses the upper byte; command bytes send zero there.
  wire [DATA_W-1:0] seq_data = (use_user && op == FHC_OP_PROGRAM) ? udata : {8'h00, seq_word[7:0]};

  // The poll address is the operation's own address every time.
  assign cyc.req   = (state == S_WRITE) || (state == S_READ) || (state == S_POLL);
  assign cyc.wr    = (state == S_WRITE);
  assign cyc.addr  = (state == S_WRITE) ? seq_addr : uaddr;
  assign cyc.wdata = seq_data;

  // Completion is a repeat of the toggle bit, never its level.
  wire tog_now     = cyc.rdata[TOGGLE_BIT];
  wire toggle_same = !first && (tog_now == prev_tog);
  wire timer_zero  = (timer == '0);
  wire poll_ack    = (state == S_POLL) && cyc.ack;
  wire tmo_err     = poll_ack && !toggle_same && timer_zero;
  wire write_end   = (state == S_WRITE) && cyc.ack && last_step;

  // Wait limit per operation; erases are long and a user may shorten them.
  always_comb begin
    case (op)
      FHC_OP_PROGRAM:      tmo_val = TMO_W'(PROG_CYC);
      FHC_OP_SECTOR_ERASE: tmo_val = small_sec ? SMALL_ERASE_TMO : LARGE_ERASE_TMO;
      FHC_OP_CHIP_ERASE:   tmo_val = CHIP_ERASE_TMO;
      FHC_OP_SUSPEND:      tmo_val = TMO_W'(SUSP_CYC);
      default:             tmo_val = '0;
    endcase
  end

  // Sequencer next state.
  always_comb begin
    next_state = state;
    case (state)
      S_RESET: if (rst_cnt == CNT_W'(RP_CYC)) next_state = S_IDLE;
      S_IDLE: if (cmd_valid_i) next_state = (cmd_op_i == FHC_OP_READ) ? S_READ : S_WRITE;
      S_WRITE: if (write_end) begin
        next_state = poll_op ? S_POLL : (op == FHC_OP_SUSPEND) ? S_SUSP_WAIT : S_IDLE;
      end
      S_READ: if (cyc.ack) next_state = S_IDLE;
      S_POLL: if (poll_ack && (toggle_same || timer_zero)) next_state = S_IDLE;
      S_SUSP_WAIT: if (timer_zero) next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  // State, flash reset pulse and user handshake flags.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state <= S_RESET;
      rst_cnt <= '0;
      flash_rst_n_o <= 1'b0;
      cmd_ready_o <= 1'b0;
      done_o <= 1'b0;
      error_o <= 1'b0;
    end else begin
      state <= next_state;
      rst_cnt <= (state == S_RESET) ? rst_cnt + 1'b1 : rst_cnt;
      flash_rst_n_o <= (next_state != S_RESET);
      cmd_ready_o <= (next_state == S_IDLE);
      done_o <= (state != S_IDLE) && (state != S_RESET) && (next_state == S_IDLE) && !tmo_err;
      error_o <= tmo_err;
    end
  end

  // Command capture and step counter.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      op <= FHC_OP_READ;
      uaddr <= '0;
      udata <= '0;
      step <= '0;
      rdata_o <= '0;
    end else begin
      if (state == S_IDLE && cmd_valid_i) begin
        op <= cmd_op_i;
        uaddr <= cmd_addr_i;
        udata <= cmd_data_i;
        step <= '0;
      end else if (state == S_WRITE && cyc.ack && !last_step) begin
        step <= step + 1'b1;
      end
      if (state == S_READ && cyc.ack) begin
        rdata_o <= cyc.rdata;
      end
    end
  end

  // Timeout counter and toggle history.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      timer <= '0;
      first <= 1'b1;
      prev_tog <= 1'b0;
    end else begin
      if (write_end) begin
        timer <= tmo_val;
        first <= 1'b1;
      end else if (!timer_zero) begin
        timer <= timer - 1'b1;
      end
      if (poll_ack) begin
        first <= 1'b0;
        prev_tog <= tog_now;
      end
    end
  end

  wire in_poll = (state == S_POLL);
  wire in_susp = (state == S_SUSP_WAIT);

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_chip_erase_addr: assert property ((write_end && op == FHC_OP_CHIP_ERASE) |-> cyc.addr == 21'h00_0555)
    else $error("Chip erase last write not at 555.");
  a_erase_last_data: assert property ((write_end && op == FHC_OP_SECTOR_ERASE) |-> cyc.wdata == 16'h0030)
    else $error("Sector erase last write data wrong.");
  a_chip_last_data: assert property ((write_end && op == FHC_OP_CHIP_ERASE) |-> cyc.wdata == 16'h0010)
    else $error("Chip erase last write data wrong.");
  // The first poll cycle follows the last command write, whose address may differ.
  a_poll_same_addr: assert property ((in_poll && $past(in_poll) && cyc.req) |-> cyc.addr == $past(cyc.addr))
    else $error("Poll address changed.");
  a_toggle_compare: assert property ((poll_ack && (first || tog_now != prev_tog)) |=> !done_o)
    else $error("Done reported without a steady toggle bit.");
  a_chip_tmo_load: assert property ((in_poll && !$past(in_poll) && op == FHC_OP_CHIP_ERASE)
                                     |-> timer == CHIP_ERASE_TMO)
    else $error("Chip erase timeout not loaded.");
  a_suspend_quiet: assert property ((in_susp && !$past(in_susp)) |-> (!cyc.req && timer == TMO_W'(SUSP_CYC)))
    else $error("Suspend latency not respected.");
  a_cmd_upper_byte: assert property ((cyc.wr && !(use_user && op == FHC_OP_PROGRAM)) |-> cyc.wdata[15:8] == 8'h00)
    else $error("Command write drives upper data byte.");
  a_error_no_done: assert property (error_o |-> (!done_o && cmd_ready_o))
    else $error("Error and done together.");

  c_program_done: cover property (done_o && op == FHC_OP_PROGRAM);
  c_chip_erase_poll: cover property (in_poll && op == FHC_OP_CHIP_ERASE);
  c_timeout: cover property (error_o);
  c_id_read: cover property (done_o && op == FHC_OP_READ);
endmodule

// ### verif/fhc_flash_model.sv
// Behavioural parallel NOR flash that answers the host controller's pins.
`timescale 1ns/1ps
module fhc_flash_model #(
  parameter int          PROG_BUSY  = 80,
  parameter int          SMALL_BUSY = 100,
  parameter int          LARGE_BUSY = 300,
  parameter int          CHIP_BUSY  = 200,
  parameter logic [15:0] MAKER_ID   = 16'h00A5,  // Arbitrary value.
  parameter logic [15:0] PART_ID    = 16'h0123,  // Arbitrary value.
  parameter logic [15:0] EXTRA_ID   = 16'h0042   // Arbitrary value.
) (
  input  wire logic                        clk_sys_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        ce_n_i,
  input  wire logic                        oe_n_i,
  input  wire logic                        we_n_i,
  input  wire logic [fhc_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [fhc_pkg::DATA_W-1:0]  dq_i,
  output logic [fhc_pkg::DATA_W-1:0]       dq_o
);
  import fhc_pkg::*;
  logic [15:0] mem [int];
  logic [2:0]  step = 3'h0;
  logic        id_mode = 1'b0;
  logic        tog = 1'b0;
  logic        prev_we = 1'b1;
  logic        prev_rd = 1'b0;
  logic [15:0] last_rd = 16'h0000;
  int          busy = 0;
  // Commands decode only the low data byte and the low address bits.
  wire         rd_now = !ce_n_i && !oe_n_i;
  wire [7:0]   cdat = dq_i[7:0];
  wire [11:0]  cadr = addr_i[11:0];

  // Small sectors sit in the top 32K words and are 4K words each.
  function automatic int sec(input int a);
    return (a[20:15] == 6'h3F) ? (a >> 12) : (a >> 15);
  endfunction

  // Status while busy, codes in identification mode, else the array.
  function automatic logic [15:0] rd_word(input logic [20:0] a);
    if (busy > 0) return {9'h000, tog, 6'h00};
    if (id_mode && a[20:2] == '0 && !a[1]) return a[0] ? PART_ID : MAKER_ID;
    if (id_mode && a[20:0] == 21'h00_0003) return EXTRA_ID;
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction

  // Pins are sampled each cycle; a released bus shows the inverse of the last read so it never looks valid.
  always @(posedge clk_sys_i) begin
    prev_we <= we_n_i;
    prev_rd <= rd_now;
    dq_o <= rd_now ? rd_word(addr_i) : ~last_rd;
    if (prev_rd && !rd_now) begin
      last_rd <= dq_o;
      if (busy > 0) tog <= ~tog;
    end
    if (busy > 0) busy <= busy - 1;
    if (!rst_n_i) begin
      step <= 3'h0;
      id_mode <= 1'b0;
      busy <= 0;
      tog <= 1'b0;
    end else if (!prev_we && we_n_i && !ce_n_i && busy == 0) begin
      step <= 3'h0;
      if (id_mode && cdat == 8'hF0) id_mode <= 1'b0;
      case (step)
        3'h0, 3'h4: if (cdat == 8'hAA && cadr == 12'h555) step <= step + 3'h1;
        3'h1, 3'h5: if (cdat == 8'h55 && cadr == 12'h2AA) step <= step + 3'h1;
        3'h2: begin
          if (cadr == 12'h555 && cdat == 8'hA0) step <= 3'h3;
          if (cadr == 12'h555 && cdat == 8'h80) step <= 3'h4;
          if (cadr == 12'h555 && cdat == 8'h90) id_mode <= 1'b1;
        end
        3'h3: begin
          mem[addr_i] = (mem.exists(addr_i) ? mem[addr_i] : 16'hFFFF) & dq_i;
          busy <= PROG_BUSY;
        end
        3'h6: begin
          if (cdat == 8'h30) begin
            foreach (mem[k]) if (sec(k) == sec(addr_i)) mem[k] = 16'hFFFF;
            busy <= (addr_i[20:15] == 6'h3F) ? SMALL_BUSY : LARGE_BUSY;
          end
          if (cdat == 8'h10 && cadr == 12'h555) begin
            mem.delete();
            busy <= CHIP_BUSY;
          end
        end
        default: ;
      endcase
    end
  end
endmodule

// ### verif/fhc_ctrl_tb_top.sv
// Self-checking bench for the flash host controller against the flash model.
`timescale 1ns/1ps
module fhc_ctrl_tb_top;
  import fhc_pkg::*;
  localparam int          LARGE_TMO = 150;
  localparam logic [15:0] MAKER = 16'h00A5;  // Arbitrary value.
  localparam logic [15:0] PART  = 16'h0123;  // Arbitrary value.
  localparam logic [15:0] EXTRA = 16'h0042;  // Arbitrary value.
  typedef struct {
    fhc_op_type        op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              chk;
    logic [DATA_W-1:0] exp;
    int                min_cyc;
  } fhc_row_type;
  fhc_row_type       rows [20];
  logic              clk_sys_i = 1'b0;
  logic              rst = 1'b1;
  logic              cmd_valid = 1'b0;
  fhc_op_type        cmd_op = FHC_OP_READ;
  logic [ADDR_W-1:0] cmd_addr = '0;
  logic [DATA_W-1:0] cmd_data = '0;
  logic              cmd_ready_o, done_o, error_o, flash_rst_n_o;
  logic              flash_ce_n_o, flash_oe_n_o, flash_we_n_o, flash_dq_oe_o;
  logic [ADDR_W-1:0] flash_addr_o;
  logic [DATA_W-1:0] flash_dq_o, flash_dq_i, rdata_o;
  int                compares = 0;
  int                miscompares = 0;
  int                cyc;
  logic              err;

  fhc_ctrl #(.SMALL_ERASE_TMO(400), .LARGE_ERASE_TMO(LARGE_TMO), .CHIP_ERASE_TMO(400)) fhc_ctrl_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst), .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr),
    .cmd_data_i(cmd_data), .cmd_ready_o(cmd_ready_o), .done_o(done_o), .error_o(error_o), .rdata_o(rdata_o),
    .flash_rst_n_o(flash_rst_n_o), .flash_ce_n_o(flash_ce_n_o), .flash_oe_n_o(flash_oe_n_o),
    .flash_we_n_o(flash_we_n_o), .flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o),
    .flash_dq_oe_o(flash_dq_oe_o), .flash_dq_i(flash_dq_i));

  // The large sector stays busy past the host's limit so its timeout path is reached.
  fhc_flash_model #(.LARGE_BUSY(2 * LARGE_TMO), .MAKER_ID(MAKER), .PART_ID(PART), .EXTRA_ID(EXTRA)) fhc_flash_model_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(flash_rst_n_o), .ce_n_i(flash_ce_n_o), .oe_n_i(flash_oe_n_o),
    .we_n_i(flash_we_n_o), .addr_i(flash_addr_o), .dq_i(flash_dq_o), .dq_o(flash_dq_i));

  // Clock at 20 MHz.
  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // One command: request after a ready cycle, then count cycles up to done or error.
  task automatic run_op(input fhc_op_type op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    do @(negedge clk_sys_i); while (cmd_ready_o !== 1'b1);
    @(posedge clk_sys_i);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    @(posedge clk_sys_i);
    cmd_valid <= 1'b0;
    cyc = 0;
    while (cyc < 3000 && done_o !== 1'b1 && error_o !== 1'b1) begin
      @(negedge clk_sys_i);
      cyc++;
    end
    check("answer", done_o | error_o, 1'b1);
    err = error_o;
  endtask

  // Reset for 16 cycles; the flash reset must stay low for at least the reset pulse width.
  task automatic do_reset;
    int n;
    @(posedge clk_sys_i);
    rst <= 1'b1;
    repeat (16) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    check("pins in reset", {flash_ce_n_o, flash_oe_n_o, flash_we_n_o, flash_dq_oe_o, cmd_ready_o, flash_rst_n_o},
          6'b11_1000);
    @(posedge clk_sys_i);
    rst <= 1'b0;
    n = 0;
    while (n < 100 && flash_rst_n_o !== 1'b1) begin
      @(negedge clk_sys_i);
      n++;
    end
    check("reset pulse", n >= RP_CYC, 1'b1);
  endtask

  // Output enable must stay high whenever write strobe and chip select are both low.
  always @(negedge clk_sys_i) begin
    if (!rst && flash_we_n_o === 1'b0 && flash_ce_n_o === 1'b0) begin
      check("oe in write", flash_oe_n_o, 1'b1);
      check("dq drive in write", flash_dq_oe_o, 1'b1);
    end
  end

  initial begin
    #(40000 * 50);
    miscompares++;
    finish_test();
  end

  initial begin
    rows = '{
      '{FHC_OP_READ, 21'h00_0100, 16'h0000, 1'b1, 16'hFFFF, 0},
      '{FHC_OP_PROGRAM, 21'h00_0100, 16'h1234, 1'b0, 16'h0000, 80},
      '{FHC_OP_READ, 21'h00_0100, 16'h0000, 1'b1, 16'h1234, 0},
      '{FHC_OP_PROGRAM, 21'h1F_8010, 16'hA5C3, 1'b0, 16'h0000, 80},
      '{FHC_OP_ID_ENTRY, 21'h00_0000, 16'h0000, 1'b0, 16'h0000, 0},
      '{FHC_OP_READ, 21'h00_0000, 16'h0000, 1'b1, MAKER, 0},
      '{FHC_OP_READ, 21'h00_0001, 16'h0000, 1'b1, PART, 0},
      '{FHC_OP_READ, 21'h00_0003, 16'h0000, 1'b1, EXTRA, 0},
      '{FHC_OP_ID_EXIT, 21'h00_0000, 16'h0000, 1'b0, 16'h0000, 0},
      '{FHC_OP_READ, 21'h00_0000, 16'h0000, 1'b1, 16'hFFFF, 0},
      '{FHC_OP_ID_ENTRY, 21'h00_0000, 16'h0000, 1'b0, 16'h0000, 0},
      '{FHC_OP_ID_EXIT_SHORT, 21'h00_0000, 16'h0000, 1'b0, 16'h0000, 0},
      '{FHC_OP_READ, 21'h00_0001, 16'h0000, 1'b1, 16'hFFFF, 0},
      '{FHC_OP_SECTOR_ERASE, 21'h1F_8000, 16'h0000, 1'b0, 16'h0000, 100},
      '{FHC_OP_READ, 21'h1F_8010, 16'h0000, 1'b1, 16'hFFFF, 0},
      '{FHC_OP_READ, 21'h00_0100, 16'h0000, 1'b1, 16'h1234, 0},
      '{FHC_OP_CHIP_ERASE, 21'h00_0000, 16'h0000, 1'b0, 16'h0000, 200},
      '{FHC_OP_READ, 21'h00_0100, 16'h0000, 1'b1, 16'hFFFF, 0},
      '{FHC_OP_SUSPEND, 21'h00_0100, 16'h0000, 1'b0, 16'h0000, SUSP_CYC},
      '{FHC_OP_RESUME, 21'h00_0100, 16'h0000, 1'b0, 16'h0000, 0}};
    do_reset();
    // Ordinary cases: programs, identification entry and both exits, erases and suspend.
    foreach (rows[i]) begin
      run_op(rows[i].op, rows[i].addr, rows[i].data);
      check("no timeout", err, 1'b0);
      check("latency", cyc >= rows[i].min_cyc, 1'b1);
      if (rows[i].chk) check("rdata", rdata_o, rows[i].exp);
    end
    // Identification mode is entered and then lost through a second reset in mid-run.
    run_op(FHC_OP_ID_ENTRY, 21'h00_0000, 16'h0000);
    do_reset();
    run_op(FHC_OP_READ, 21'h00_0000, 16'h0000);
    check("array after reset", rdata_o, 16'hFFFF);
    // A large sector that stays busy beyond the host's limit must end in an error.
    run_op(FHC_OP_SECTOR_ERASE, 21'h00_8000, 16'h0000);
    check("erase timeout", err, 1'b1);
    check("timeout span", cyc >= LARGE_TMO, 1'b1);
    finish_test();
  end
endmodule
